/* File: src/mtcs_map.svh */
/*
 * Register offsets, field positions, reset values and timing figures
 * of the conversion sequencer. Assumes a 32-bit APB slave, byte addresses.
 */
`ifndef MTCS_MAP_SVH
`define MTCS_MAP_SVH

`define MTCS_OFS_CTRL 8'h00
`define MTCS_OFS_STATUS 8'h04
`define MTCS_OFS_IRQ_STAT 8'h08
`define MTCS_OFS_IRQ_MASK 8'h0C
`define MTCS_OFS_RESULT 8'h20
`define MTCS_OFS_HIGH_LIMIT 8'h40
`define MTCS_OFS_LOW_LIMIT 8'h60

`define MTCS_CTRL_START 0
`define MTCS_CTRL_AUTO 1
`define MTCS_CTRL_STANDBY 2
`define MTCS_STATUS_BUSY 0
`define MTCS_STATUS_STANDBY 1
`define MTCS_IRQ_DONE 0
`define MTCS_IRQ_ALARM 1
`define MTCS_IRQ_ABORT 2
`define MTCS_IRQ_BITS 3

`define MTCS_HIGH_LIMIT_RST 8'h7F
`define MTCS_LOW_LIMIT_RST 8'hC9
`define MTCS_RESULT_RST 8'h00

`define MTCS_INTEG_MS 64
`define MTCS_CLK_KHZ 125000
`define MTCS_INTEG_CYCLES (`MTCS_INTEG_MS * `MTCS_CLK_KHZ)

`endif

/* File: src/mtcs_pkg.sv */
/*
 * Types of the conversion sequencer.
 * Assumes mtcs_map.svh supplies the numeric constants.
 */
package mtcs_pkg;
    typedef enum logic [1:0] {
        MTCS_IDLE = 2'b01,
        MTCS_CONV = 2'b10
    } mtcs_state_t;

    // analog front-end steering
    typedef struct packed {
        logic bias_en;
        logic [2:0] mux_sel;
    } mtcs_fe_t;
endpackage

/* File: src/mtcs_top.sv */
/*
 * Conversion sequencer with APB registers, limit compare, alarm pin
 * and interrupt. Assumes the front end presents a settled 8-bit code
 * on adc_code by the end of each integration period.
 */
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "mtcs_map.svh"

// What this block does
// - The five-channel build holds five results and ten limit registers and compares each result with its limits.
// - The three-channel build holds three results and six limit registers with the same comparison.
// - Each channel gets an integration period of 64 ms in the pass.
// - A started pass steps through every channel on its own, steering bias and mux to each.
// - Every channel is converted on every pass, used or not.
// - A pass starts on a start command or, in autoconvert mode, by itself.
// - Results become readable only once the whole pass has finished.
// - A busy flag in the status register is set while a pass runs.
// - During a pass, result reads return the previous complete pass.
// - The alarm pin is driven while any result reaches or passes its limit.
// - Reset loads high limits with 8'h7F and low limits with 8'hC9.
// - Standby during a pass truncates it and keeps the old results.
// - Each result is an 8-bit two's complement value, one degree per bit.
module mtcs_top #(
    parameter int NUM_CH = 5,
    parameter int INTEG_CYCLES = `MTCS_INTEG_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic standby_pin_n,
    input wire logic [7:0] adc_code,
    output mtcs_pkg::mtcs_fe_t fe_ctrl,
    input wire logic alert_in,
    output logic alert_out,
    output logic alert_oe,
    output logic irq
);
    import mtcs_pkg::*;

    localparam int CW = $clog2(INTEG_CYCLES + 1);

    // the decode and the channel counter only serve these builds
    if (NUM_CH != 5 && NUM_CH != 3) begin : g_bad_ch
        $error("NUM_CH must be 3 or 5");
    end
    if (INTEG_CYCLES < 1) begin : g_bad_integ
        $error("INTEG_CYCLES must be at least 1");
    end

    // synchronisers for pins
    logic standby_pin_m_r, standby_pin_s_r;
    logic [7:0] adc_m_r, adc_s_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_pin_m_r <= 1'b0;
            standby_pin_s_r <= 1'b0;
            adc_m_r <= 8'h00;
            adc_s_r <= 8'h00;
        end else begin
            standby_pin_m_r <= standby_pin_n;
            standby_pin_s_r <= standby_pin_m_r;
            adc_m_r <= adc_code;
            adc_s_r <= adc_m_r;
        end
    end

    // registers
    logic start_r, auto_r, sw_standby_pin_r;
    logic [`MTCS_IRQ_BITS-1:0] irq_stat_r, irq_mask_r;
    logic [NUM_CH-1:0][7:0] res_r, shadow_r, high_r, low_r;
    mtcs_state_t state_r;
    logic busy_r;
    logic [2:0] ch_r;
    logic [CW-1:0] cnt_r;
    logic pready_r, pslverr_r, irq_r, alert_oe_r, alarm_d_r;
    logic [31:0] prdata_r;

    // bus decode
    wire setup = psel && !penable;
    wire [2:0] sub = paddr[4:2];
    wire in_res = paddr[7:5] == `MTCS_OFS_RESULT >> 5 && sub < NUM_CH;
    wire in_hi = paddr[7:5] == `MTCS_OFS_HIGH_LIMIT >> 5 && sub < NUM_CH;
    wire in_lo = paddr[7:5] == `MTCS_OFS_LOW_LIMIT >> 5 && sub < NUM_CH;
    wire is_ctrl = paddr == `MTCS_OFS_CTRL;
    wire is_stat = paddr == `MTCS_OFS_STATUS;
    wire is_ist = paddr == `MTCS_OFS_IRQ_STAT;
    wire is_imsk = paddr == `MTCS_OFS_IRQ_MASK;
    wire mapped = (is_ctrl || is_stat || is_ist || is_imsk || in_res
        || in_hi || in_lo) && paddr[1:0] == 2'b00;
    // unmapped or misaligned writes are refused, not aliased
    wire wr_en = psel && penable && pready_r && pwrite && mapped;
    wire standby_pin = !standby_pin_s_r || sw_standby_pin_r;
    wire [31:0] rd_val =
        is_ctrl ? {29'h0, sw_standby_pin_r, auto_r, 1'b0} :
        is_stat ? {30'h0, standby_pin, busy_r} :
        is_ist ? {29'h0, irq_stat_r} :
        is_imsk ? {29'h0, irq_mask_r} :
        in_res ? {24'h0, res_r[sub]} :
        in_hi ? {24'h0, high_r[sub]} :
        in_lo ? {24'h0, low_r[sub]} : 32'h0;

    // sequencer decode
    wire tick = cnt_r == CW'(INTEG_CYCLES - 1);
    wire last_ch = ch_r == 3'(NUM_CH - 1);
    wire conv = state_r == MTCS_CONV;
    wire abort = conv && standby_pin;
    wire ch_done = conv && !standby_pin && tick;
    wire latch_all = ch_done && last_ch;
    wire go = state_r == MTCS_IDLE && !standby_pin && (start_r || auto_r);
    // newest sample joined with the shadow copy of the pass
    logic [NUM_CH-1:0][7:0] shadow_nxt;
    always_comb begin
        shadow_nxt = shadow_r;
        shadow_nxt[ch_r] = adc_s_r;
    end

    // assertion helper: channels finished in the current pass
    logic [2:0] done_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_cnt_r <= 3'h0;
        end else if (go) begin
            done_cnt_r <= 3'h0;
        end else if (ch_done) begin
            done_cnt_r <= done_cnt_r + 3'h1;
        end
    end

    // limit compare, both limits inclusive
    logic [NUM_CH-1:0] alarm_ch;
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_cmp
            assign alarm_ch[g] = $signed(res_r[g]) >= $signed(high_r[g])
                || $signed(res_r[g]) <= $signed(low_r[g]);
        end
    endgenerate
    wire alarm_any = |alarm_ch;
    wire [`MTCS_IRQ_BITS-1:0] ev = {abort, alarm_any && !alarm_d_r,
        latch_all};
    wire [`MTCS_IRQ_BITS-1:0] w1c = (wr_en && is_ist) ?
        pwdata[`MTCS_IRQ_BITS-1:0] : '0;
    // set wins over a simultaneous clear
    wire [`MTCS_IRQ_BITS-1:0] irq_stat_nxt = (irq_stat_r & ~w1c) | ev;

    // apb slave: one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r <= setup && !pwrite ? rd_val : 32'h0;
        end
    end

    // software registers; start is a pulse consumed by the sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_r <= 1'b0;
            auto_r <= 1'b0;
            sw_standby_pin_r <= 1'b0;
            irq_mask_r <= '0;
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= irq_stat_nxt;
            start_r <= wr_en && is_ctrl && pwdata[`MTCS_CTRL_START];
            if (wr_en && is_ctrl) begin
                auto_r <= pwdata[`MTCS_CTRL_AUTO];
                sw_standby_pin_r <= pwdata[`MTCS_CTRL_STANDBY];
            end
            if (wr_en && is_imsk)
                irq_mask_r <= pwdata[`MTCS_IRQ_BITS-1:0];
        end
    end

    // limits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_r <= {NUM_CH{`MTCS_HIGH_LIMIT_RST}};
            low_r <= {NUM_CH{`MTCS_LOW_LIMIT_RST}};
        end else begin
            if (wr_en && in_hi)
                high_r[sub] <= pwdata[7:0];
            if (wr_en && in_lo)
                low_r[sub] <= pwdata[7:0];
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= MTCS_IDLE;
            busy_r <= 1'b0;
            ch_r <= 3'h0;
            cnt_r <= '0;
            shadow_r <= '0;
            res_r <= {NUM_CH{`MTCS_RESULT_RST}};
        end else begin
            unique case (state_r)
                MTCS_IDLE: begin
                    cnt_r <= '0;
                    ch_r <= 3'h0;
                    if (go) begin
                        state_r <= MTCS_CONV;
                        busy_r <= 1'b1;
                    end
                end
                MTCS_CONV: begin
                    if (abort) begin
                        // truncated pass: shadow is simply dropped
                        state_r <= MTCS_IDLE;
                        busy_r <= 1'b0;
                    end else if (tick) begin
                        cnt_r <= '0;
                        shadow_r <= shadow_nxt;
                        if (last_ch) begin
                            res_r <= shadow_nxt;
                            busy_r <= 1'b0;
                            state_r <= MTCS_IDLE;
                        end else begin
                            ch_r <= ch_r + 3'h1;
                        end
                    end else begin
                        cnt_r <= cnt_r + CW'(1);
                    end
                end
            endcase
        end
    end

    // outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fe_ctrl <= '0;
            alert_oe_r <= 1'b0;
            alarm_d_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            fe_ctrl.bias_en <= conv && !standby_pin;
            fe_ctrl.mux_sel <= ch_r;
            alert_oe_r <= alarm_any;
            alarm_d_r <= alarm_any;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign alert_out = 1'b0;
    assign alert_oe = alert_oe_r;
    assign irq = irq_r;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    res_hold_a: assert property (!latch_all |=> $stable(res_r))
        else $error("results changed outside a pass end");
    abort_keep_a: assert property (abort |=> !busy_r && $stable(res_r))
        else $error("standby did not truncate the pass");
    busy_set_a: assert property (go |=> busy_r && conv)
        else $error("busy not set on pass start");
    busy_clear_a: assert property (latch_all |=> !busy_r && !conv)
        else $error("busy not cleared at last latch");
    ch_step_a: assert property (ch_done && !last_ch |=>
        ch_r == $past(ch_r) + 3'h1)
        else $error("channel order broken");
    all_ch_a: assert property (latch_all |-> done_cnt_r == 3'(NUM_CH - 1))
        else $error("pass ended before last channel");
    period_a: assert property (conv && cnt_r == '0 && !standby_pin ##1
        (conv && !standby_pin) [*2] |-> cnt_r == CW'(2))
        else $error("integration count not advancing");
    latch_val_a: assert property (latch_all |=>
        res_r[NUM_CH-1] == $past(adc_s_r))
        else $error("last result not latched");
    alert_pin_a: assert property (alarm_any |=> alert_oe && !alert_out)
        else $error("alarm pin not driven");
    auto_run_a: assert property (state_r == MTCS_IDLE && auto_r && !standby_pin
        |=> busy_r)
        else $error("autoconvert did not start a pass");
    irq_level_a: assert property (|(irq_stat_r & irq_mask_r) |=> irq)
        else $error("interrupt not raised");
    set_wins_a: assert property ((|ev) |=>
        (irq_stat_r & $past(ev)) == $past(ev))
        else $error("event lost to a same-cycle clear");
    fe_steer_a: assert property (conv && !standby_pin |=> fe_ctrl.bias_en
        && fe_ctrl.mux_sel == $past(ch_r))
        else $error("front end not steered to the channel");
    standby_pin_block_a: assert property (standby_pin |=> !busy_r)
        else $error("pass running in standby");
    limit_wr_a: assert property (wr_en && in_hi |=>
        high_r[$past(sub)] == $past(pwdata[7:0]))
        else $error("high limit write lost");
    alarm_off_a: assert property (!alarm_any |=> !alert_oe)
        else $error("alarm pin driven without alarm");
endmodule

/* File: verif/mtcs_fe_model.sv */
/*
 * Front-end model: returns a fixed code per channel while biased.
 * Assumes the sequencer steers it through fe_ctrl on pclk.
 */
`timescale 1ns/100ps
module mtcs_fe_model (
    input wire logic pclk,
    input mtcs_pkg::mtcs_fe_t fe_ctrl,
    input wire logic [39:0] codes,
    output logic [7:0] adc_code
);
    import mtcs_pkg::*;
    wire logic [7:0] sel_code = (fe_ctrl.mux_sel < 3'h5) ?
        codes[fe_ctrl.mux_sel*8 +: 8] : 8'h5A;
    // unbiased diode gives no valid code, so show garbage on purpose
    assign adc_code = fe_ctrl.bias_en ? sel_code : ~sel_code;
endmodule

/* File: verif/multichannel_temp_conversion_sequencer_tb.sv */
/*
 * Bench: APB tasks and directed sequences over one 5-channel sequencer.
 * Assumes mtcs_top with short integration and the front-end model.
 */
`timescale 1ns/100ps
`include "mtcs_map.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_total++; \
$display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module multichannel_temp_conversion_sequencer_tb;
    import mtcs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic standby_pin_n = 1, pready, pslverr, alert_oe, irq, rerr, alert_out;
    logic [7:0] paddr = 0, adc_code;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [39:0] codes = 40'h3228_1E14_0A, old;
    mtcs_fe_t fe_ctrl;
    int err_total = 0, check_count = 0, bias_cnt = 0, i, j, k;
    int seq[$];
    logic [7:0] la[4] = '{8'h48, 8'h48, 8'h60, 8'h60};
    logic [31:0] lv[4] = '{32'h1E, 32'h7F, 32'h0A, 32'hC9};
    logic le[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    always #4 pclk = ~pclk;
    mtcs_top #(.NUM_CH(5), .INTEG_CYCLES(8)) DUT (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .standby_pin_n(standby_pin_n),
        .adc_code(adc_code), .fe_ctrl(fe_ctrl), .alert_in(~alert_oe),
        .alert_out(alert_out), .alert_oe(alert_oe), .irq(irq));
    mtcs_fe_model fe (.pclk(pclk), .fe_ctrl(fe_ctrl), .codes(codes),
        .adc_code(adc_code));
    always @(posedge pclk) if (fe_ctrl.bias_en) begin
        bias_cnt++;
        if (seq.size() == 0 || seq[$] != fe_ctrl.mux_sel)
            seq.push_back(fe_ctrl.mux_sel);
    end
    task give_verdict;
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        rerr = pslverr;
        psel <= 0; penable <= 0;
        if (n >= 20) begin err_total++; give_verdict(); end
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 0);
        `CHK(rd, e)
    endtask
    task res_chk(input logic [39:0] c);
        for (i = 0; i < 5; i++) rdchk(8'(8'h20 + 4*i), {24'h0, c[i*8 +: 8]});
    endtask
    // bounded poll; a hung pass ends the run instead of the sim
    task wait_idle;
        k = 0;
        do begin apb(0, 8'h04, 0); k++; end while (rd[0] !== 1'b0 && k < 100);
        if (k >= 100) begin err_total++; give_verdict(); end
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        for (j = 0; j < 5; j++) begin
            rdchk(8'(8'h40 + 4*j), 32'h7F);
            rdchk(8'(8'h60 + 4*j), 32'hC9);
        end
        res_chk(40'h0);
        apb(0, 8'hFC, 0);
        `CHK(rerr, 1'b1)
        seq.delete();
        bias_cnt = 0;
        apb(1, 8'h00, 32'h1);
        repeat (2) @(posedge pclk);
        apb(0, 8'h04, 0);
        `CHK(rd[0], 1'b1)
        rdchk(8'h20, 32'h0);
        wait_idle();
        res_chk(codes);
        `CHK(seq.size(), 5)
        for (j = 0; j < 5; j++) `CHK(seq[j], j)
        `CHK(bias_cnt >= 40 && bias_cnt <= 42, 1'b1)
        rdchk(8'h08, 32'h1);
        `CHK(irq, 1'b0)
        apb(1, 8'h0C, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1, 8'h08, 32'h7);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        // equal to the limit must alarm on both the high and low side
        for (j = 0; j < 4; j++) begin
            apb(1, la[j], lv[j]);
            apb(1, 8'h00, 32'h1);
            repeat (2) @(posedge pclk);
            wait_idle();
            repeat (2) @(posedge pclk);
            `CHK(alert_oe, le[j])
            `CHK(alert_out, 1'b0)
        end
        old = codes;
        for (j = 0; j < 2; j++) begin
            codes = old ^ 40'h0101_0101_01;
            apb(1, 8'h00, 32'h1);
            repeat (10) @(posedge pclk);
            if (j == 0) apb(1, 8'h00, 32'h4);
            else standby_pin_n <= 0;
            repeat (4) @(posedge pclk);
            rdchk(8'h04, 32'h2);
            res_chk(old);
            apb(0, 8'h08, 0);
            `CHK(rd[2], 1'b1)
            apb(1, 8'h08, 32'h4);
            apb(1, 8'h00, 32'h0);
            standby_pin_n <= 1;
            repeat (4) @(posedge pclk);
        end
        apb(1, 8'h00, 32'h2);
        k = 0;
        while (fe_ctrl.bias_en !== 1'b1 && k < 50) begin
            @(posedge pclk);
            k++;
        end
        `CHK(fe_ctrl.bias_en, 1'b1)
        apb(1, 8'h00, 32'h0);
        wait_idle();
        res_chk(codes);
        give_verdict();
    end
endmodule
